// ### sld_pkg.sv
// Purpose: constants for the squib loop diagnostic sequencer
// Assumes: classic wishbone, 32-bit data, 50 MHz clock
// Notes:   register offsets are word indices; byte address is four times the index
//
// What this block does
// - loop monitor check tests one side only
// - request bit 15 selects high-level mode
// - test field 010 leakage, 011 short between
// - channel field 0000 to 0011 selects channels
// - request bit 4 picks feed or return
// - status 19 mode, status 18 running
// - status 16 reports preliminary step fault
// - status 15 driver on, zero for leakage; the code keeps it at zero for every test
// - flags: between 7, ground 6, battery 5
// - status echoes test, channel and side
// - config bit 10 selects long step timing
// - timing bit writable only in startup state
// - config bit 0 disables startup timeout
// - status word carries 20 bits
package sld_pkg;
   localparam logic [7:0] SLD_IDX_SYSCFG = 8'h01;
   localparam logic [7:0] SLD_IDX_STATUS = 8'h37;
   localparam logic [7:0] SLD_IDX_REQ    = 8'h38;
   localparam logic [7:0] SLD_IDX_CTRL   = 8'h40;

   localparam int SLD_REQ_HL      = 15;
   localparam int SLD_REQ_SIDE    = 4;
   localparam int SLD_CFG_TIME    = 10;
   localparam int SLD_CFG_TOVR    = 0;
   localparam int SLD_ST_HL       = 19;
   localparam int SLD_ST_RUN      = 18;
   localparam int SLD_ST_PRE      = 16;
   localparam int SLD_ST_FET      = 15;
   localparam int SLD_ST_SBL      = 7;
   localparam int SLD_ST_STG      = 6;
   localparam int SLD_ST_STB      = 5;

   localparam logic [2:0] SLD_TST_NONE = 3'h0;
   localparam logic [2:0] SLD_TST_VMON = 3'h1;
   localparam logic [2:0] SLD_TST_LEAK = 3'h2;
   localparam logic [2:0] SLD_TST_SBL  = 3'h3;
   localparam logic [3:0] SLD_CH_MAX   = 4'h3;

   localparam int CLK_HZ          = 50_000_000;
   localparam int STARTUP_MS      = 500;
   localparam int STARTUP_CYC     = STARTUP_MS * (CLK_HZ / 1000);
   localparam int STEP_SHORT_US   = 100;
   localparam int STEP_LONG_US    = 400;
   localparam int STEP_SHORT_CYC  = STEP_SHORT_US * (CLK_HZ / 1_000_000);
   localparam int STEP_LONG_CYC   = STEP_LONG_US * (CLK_HZ / 1_000_000);
   localparam int SLD_STEP_W      = 16;
   localparam int SLD_START_W     = 25;
   localparam logic [19:0] SLD_STATUS_RST = 20'h00000;
endpackage

// ### sld_step_timer.sv
// Purpose: step timer for the diagnostic sequence
// Assumes: start is a one-cycle pulse
// Notes:   done pulses once when the loaded count expires
`timescale 1ns/1ps
`default_nettype none
module sld_step_timer
   import sld_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // control
   input  wire logic                  start_i,
   input  wire logic                  long_i,
   output logic                       done_o
);
   logic [SLD_STEP_W-1:0] cnt_ff;
   logic                  busy_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            // step duration chosen from the timing bit
            cnt_ff  <= long_i ? SLD_STEP_W'(STEP_LONG_CYC - 1) : SLD_STEP_W'(STEP_SHORT_CYC - 1);
            busy_ff <= 1'b1;
         end else if (busy_ff) begin
            if (cnt_ff == '0) begin
               busy_ff <= 1'b0;
               done_o  <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### sld_seq.sv
// Purpose: register bank and sequencer for high-level squib loop diagnostics
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes:   analog results arrive as sampled fault inputs at the end of each step
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sld_seq
   import sld_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_CYC
)(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // analog comparator results, valid at step end
   input  wire logic        pre_fault_i,
   input  wire logic        stg_det_i,
   input  wire logic        stb_det_i,
   input  wire logic        sbl_det_i,
   // analog path control
   output logic             meas_en_o,
   output logic             feed_sel_o,
   output logic [1:0]       chan_sel_o,
   output logic             in_startup_o,
   output logic             startup_expired_o
);
   typedef enum logic [1:0] {
      SLD_IDLE = 2'b00,
      SLD_PRE  = 2'b01,
      SLD_TEST = 2'b10
   } sld_state_e;

   sld_state_e        state_ff;
   logic [15:0]       cfg_ff;
   logic [19:0]       status_ff;
   logic [SLD_START_W-1:0] start_cnt_ff;
   logic              startup_ff;
   logic              step_start_ff;
   logic              step_done;
   logic              bus_req;
   logic              wr_ok;
   logic [7:0]        idx;
   logic              hl_req;
   logic [2:0]        req_test;
   logic              req_valid;

   function automatic logic test_known(input logic [2:0] t);
      return (t == SLD_TST_VMON) || (t == SLD_TST_LEAK) || (t == SLD_TST_SBL);
   endfunction

   function automatic logic needs_pre(input logic [2:0] t);
      return t == SLD_TST_LEAK;
   endfunction

   assign bus_req   = cyc_i & stb_i & ~ack_o;
   assign idx       = adr_i[9:2];
   assign wr_ok     = bus_req & we_i & sel_i[0] & sel_i[1];
   assign hl_req    = dat_i[SLD_REQ_HL];
   assign req_test  = dat_i[7:5];
   // channel field upper values are not mapped to a loop
   assign req_valid = hl_req & test_known(req_test) & (dat_i[3:0] <= SLD_CH_MAX);

   sld_step_timer u_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (step_start_ff),
      .long_i  (cfg_ff[SLD_CFG_TIME]),
      .done_o  (step_done)
   );

   // bus answer: ack one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= bus_req;
         dat_o <= 32'h00000000;
         if (bus_req && !we_i && idx == SLD_IDX_STATUS) begin
            dat_o <= {12'h000, status_ff};
         end else if (bus_req && !we_i && idx == SLD_IDX_CTRL) begin
            dat_o <= {30'h00000000, startup_expired_o, startup_ff};
         end
      end
   end

   // startup window; host must configure timing before it closes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_cnt_ff      <= '0;
         startup_ff        <= 1'b1;
         startup_expired_o <= 1'b0;
      end else if (startup_ff) begin
         if (cfg_ff[SLD_CFG_TOVR]) begin
            start_cnt_ff <= start_cnt_ff;
         end else if (start_cnt_ff == SLD_START_W'(STARTUP_CYCLES - 1)) begin
            startup_ff        <= 1'b0;
            startup_expired_o <= 1'b1;
         end else begin
            start_cnt_ff <= start_cnt_ff + 1'b1;
         end
         // leaving startup by software write to the control word
         if (wr_ok && idx == SLD_IDX_CTRL && dat_i[0]) begin
            startup_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      in_startup_o <= rst_i ? 1'b1 : startup_ff;
   end

   // configuration; timing bit frozen outside startup
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ff <= 16'h0000;
      end else if (wr_ok && idx == SLD_IDX_SYSCFG) begin
         if (startup_ff) begin
            cfg_ff <= dat_i[15:0];
         end else begin
            cfg_ff <= {dat_i[15:11], cfg_ff[SLD_CFG_TIME], dat_i[9:0]};
         end
      end
   end

   // sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff      <= SLD_IDLE;
         status_ff     <= SLD_STATUS_RST;
         step_start_ff <= 1'b0;
         meas_en_o     <= 1'b0;
         feed_sel_o    <= 1'b0;
         chan_sel_o    <= 2'b00;
      end else begin
         step_start_ff <= 1'b0;
         case (state_ff)
            SLD_IDLE: begin
               if (wr_ok && idx == SLD_IDX_REQ) begin
                  // a new request clears earlier results
                  status_ff <= SLD_STATUS_RST;
                  status_ff[SLD_ST_HL] <= hl_req;
                  status_ff[11:8] <= {1'b0, req_test};
                  status_ff[4] <= dat_i[SLD_REQ_SIDE];
                  status_ff[3:0] <= dat_i[3:0];
                  if (req_valid) begin
                     status_ff[SLD_ST_RUN] <= 1'b1;
                     // one side per run only
                     feed_sel_o    <= dat_i[SLD_REQ_SIDE];
                     chan_sel_o    <= dat_i[1:0];
                     meas_en_o     <= 1'b1;
                     step_start_ff <= 1'b1;
                     state_ff <= needs_pre(req_test) ? SLD_PRE : SLD_TEST;
                  end
               end
            end
            SLD_PRE: begin
               if (step_done) begin
                  if (pre_fault_i) begin
                     status_ff[SLD_ST_PRE] <= 1'b1;
                     status_ff[SLD_ST_RUN] <= 1'b0;
                     meas_en_o <= 1'b0;
                     state_ff  <= SLD_IDLE;
                  end else begin
                     step_start_ff <= 1'b1;
                     state_ff      <= SLD_TEST;
                  end
               end
            end
            SLD_TEST: begin
               if (step_done) begin
                  // no driver is switched on for these tests
                  status_ff[SLD_ST_FET] <= 1'b0;
                  if (status_ff[10:8] == SLD_TST_SBL) begin
                     status_ff[SLD_ST_SBL] <= sbl_det_i;
                  end else if (status_ff[10:8] == SLD_TST_VMON && !status_ff[4]) begin
                     // low-side check forces ground flag on a healthy path
                     status_ff[SLD_ST_STG] <= ~pre_fault_i;
                     status_ff[SLD_ST_STB] <= 1'b0;
                  end else begin
                     status_ff[SLD_ST_STG] <= stg_det_i;
                     status_ff[SLD_ST_STB] <= stb_det_i;
                  end
                  status_ff[SLD_ST_RUN] <= 1'b0;
                  meas_en_o <= 1'b0;
                  state_ff  <= SLD_IDLE;
               end
            end
            default: begin
               state_ff <= SLD_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### sld_seq_chk.sv
// Purpose: port checks for sld_seq
// Assumes: one clock, sync reset
// Notes:   run bound allows the long two-step sequence
`timescale 1ns/1ps
`default_nettype none
module sld_seq_chk
   import sld_pkg::*;
(
   // watched ports
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [9:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        meas_en_o,
   input wire logic        feed_sel_o,
   input wire logic [1:0]  chan_sel_o,
   input wire logic        in_startup_o,
   input wire logic        startup_expired_o
);
   int run_cnt_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i || !meas_en_o)
         run_cnt_ff <= 0;
      else
         run_cnt_ff <= run_cnt_ff + 1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("data outside ack");
   fet_off_a: assert property (
      ack_o && !we_i && adr_i[9:2] == SLD_IDX_STATUS |-> !dat_o[15] && dat_o[31:20] == 12'h0)
      else $error("status spare bits set");
   start_cause_a: assert property ($rose(meas_en_o) |-> ack_o || $past(ack_o))
      else $error("run without request");
   sel_hold_a: assert property (
      meas_en_o && $past(meas_en_o) |-> $stable(chan_sel_o) && $stable(feed_sel_o))
      else $error("selection moved");
   run_bound_a: assert property (run_cnt_ff <= 2 * STEP_LONG_CYC + 8)
      else $error("run too long");
   expired_hold_a: assert property (startup_expired_o |=> startup_expired_o)
      else $error("expiry dropped");
   cover property ($fell(meas_en_o));
   cover property ($fell(in_startup_o));
   cover property (ack_o && we_i && meas_en_o);
endmodule
`default_nettype wire

// ### sld_afe_model.sv
// Purpose: detector model facing sld_seq
// Assumes: levels matter only at step end
// Notes:   lines wander outside a run so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module sld_afe_model
   import sld_pkg::*;
(
   // sequencer side
   input  wire logic       clk_i,
   input  wire logic       meas_en_i,
   input  wire logic       feed_sel_i,
   input  wire logic [2:0] test_i,
   input  wire logic [3:0] fault_i,
   // detector levels
   output logic            pre_fault_o,
   output logic            stg_o,
   output logic            stb_o,
   output logic            sbl_o
);
   logic       wander_ff = 1'b0;
   logic [3:0] lvl;
   always @(posedge clk_i)
      wander_ff <= ~wander_ff;
   always_comb begin
      if (test_i == SLD_TST_VMON)
         lvl = {2'b00, ~feed_sel_i, feed_sel_i};
      else if (test_i == SLD_TST_LEAK)
         lvl = {fault_i[3], 1'b0, fault_i[1:0]};
      else
         lvl = {1'b0, fault_i[2], 2'b00};
   end
   assign {pre_fault_o, sbl_o, stg_o, stb_o} = meas_en_i ? lvl : {4{wander_ff}};
endmodule
`default_nettype wire

// ### test_squib_loop_diag_sequencer.sv
// Purpose: self-checking bench for sld_seq
// Assumes: startup window cut to 50 cycles
// Notes:   flags follow the detector model
`timescale 1ns/1ps
`default_nettype none
module test_squib_loop_diag_sequencer;
   import sld_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, meas_en_o, feed_sel_o;
   logic        in_startup_o, startup_expired_o, pre_fault_i, stg_det_i, stb_det_i, sbl_det_i;
   logic [1:0]  chan_sel_o;
   logic [2:0]  tst;
   logic [9:0]  adr_i;
   logic [31:0] dat_i, dat_o, q, rnd;
   int          errors, checks, seed, cur, len, tlong;
   sld_seq #(.STARTUP_CYCLES(50)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .pre_fault_i(pre_fault_i), .stg_det_i(stg_det_i), .stb_det_i(stb_det_i),
      .sbl_det_i(sbl_det_i), .meas_en_o(meas_en_o), .feed_sel_o(feed_sel_o),
      .chan_sel_o(chan_sel_o), .in_startup_o(in_startup_o),
      .startup_expired_o(startup_expired_o));
   sld_afe_model afe (.clk_i(clk_i), .meas_en_i(meas_en_o), .feed_sel_i(feed_sel_o),
      .test_i(tst), .fault_i(rnd[11:8]), .pre_fault_o(pre_fault_i), .stg_o(stg_det_i),
      .stb_o(stb_det_i), .sbl_o(sbl_det_i));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (meas_en_o === 1'b1)
         cur <= cur + 1;
      else begin
         if (cur != 0)
            len <= cur;
         cur <= 0;
      end
   end
   task automatic complete_run;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_up;
      errors++;
      complete_run();
   endtask
   task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20)
         give_up();
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic run(input logic [2:0] t, input logic s, input logic [3:0] c);
      logic [19:0] e;
      int st;
      tst <= t;
      e = {4'hC, 5'h00, t, 3'b000, s, c};
      wb(1'b1, SLD_IDX_REQ, {16'h0, 1'b1, 7'h0, t, s, c});
      wb(1'b1, SLD_IDX_REQ, {16'h0, 1'b1, 7'h0, t, ~s, ~c});
      wb(1'b0, SLD_IDX_STATUS, 32'h0);
      chk(q, {12'h0, e});
      chk({29'h0, chan_sel_o, feed_sel_o}, {29'h0, c[1:0], s});
      st = 0;
      while (meas_en_o !== 1'b0 && st < 30000) begin
         @(posedge clk_i);
         st++;
      end
      if (st >= 30000)
         give_up();
      @(posedge clk_i);
      e[18] = 1'b0;
      e[16] = t == SLD_TST_LEAK && rnd[11];
      if (t == SLD_TST_VMON)
         e[7:5] = {1'b0, ~s, s};
      else if (t == SLD_TST_SBL)
         e[7:5] = {rnd[10], 2'b00};
      else if (!rnd[11])
         e[7:5] = {1'b0, rnd[9:8]};
      st = (t == SLD_TST_LEAK && !rnd[11]) ? 2 * STEP_SHORT_CYC : STEP_SHORT_CYC;
      // long timing only used with single-step checks here
      if (tlong != 0)
         st = STEP_LONG_CYC;
      wb(1'b0, SLD_IDX_STATUS, 32'h0);
      chk(q, {12'h0, e});
      chk({31'h0, len >= st - 4 && len <= st + 4}, 32'h1);
   endtask
   initial begin
      {rst_i, cyc_i, stb_i, we_i} = 4'h8;
      {adr_i, dat_i, rnd} = '0;
      {errors, checks, cur, len, tlong} = '0;
      tst = 3'h0;
      seed = 46788;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, SLD_IDX_SYSCFG, 32'h1);
      repeat (100) @(posedge clk_i);
      chk({30'h0, in_startup_o, startup_expired_o}, 32'h2);
      wb(1'b0, SLD_IDX_STATUS, 32'h0);
      chk(q, {12'h0, SLD_STATUS_RST});
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, SLD_IDX_CTRL, 32'h1);
      wb(1'b1, SLD_IDX_SYSCFG, 32'h401);
      chk({31'h0, in_startup_o}, 32'h0);
      wb(1'b1, SLD_IDX_REQ, {24'h0, SLD_TST_LEAK, 1'b1, 4'h2});
      repeat (5) @(posedge clk_i);
      chk({31'h0, meas_en_o}, 32'h0);
      wb(1'b0, SLD_IDX_STATUS, 32'h0);
      chk(q, {21'h0, SLD_TST_LEAK, 3'b000, 1'b1, 4'h2});
      for (int i = 0; i < 6; i++) begin
         rnd = $random(seed);
         rnd[11] = i > 2;
         run(3'(i % 3 + 1), i[0], {2'b00, rnd[1:0]});
      end
      // second reset: the timing bit is only writable in startup
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, SLD_IDX_SYSCFG, 32'h401);
      tlong = 1;
      rnd = $random(seed);
      run(SLD_TST_VMON, 1'b1, {2'b00, rnd[1:0]});
      complete_run();
   end
endmodule
bind sld_seq sld_seq_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .meas_en_o(meas_en_o),
   .feed_sel_o(feed_sel_o), .chan_sel_o(chan_sel_o), .in_startup_o(in_startup_o),
   .startup_expired_o(startup_expired_o));
`default_nettype wire
